// ==== psd_map.vh ====
`ifndef PSD_MAP_VH
`define PSD_MAP_VH

// Command-address phase: six bytes, one per link clock edge
`define PSD_CA_BYTES 3'd6
`define PSD_CA_LAST 3'd5
`define PSD_CA_W 48
// Direction bit inside the first command-address byte (1 = read)
`define PSD_CA_RD_BIT 7
// Initial latency in link clocks, doubled when extra latency is flagged
`define PSD_LAT_CLKS 5'd6
// Edges per link clock
`define PSD_EDGES_PER_CLK 2
// Bit positions inside the synchroniser vector
`define PSD_SY_CS 0
`define PSD_SY_CK 1
`define PSD_SY_CKN 2
`define PSD_SY_PSC 3
`define PSD_SY_PSCN 4
`define PSD_SY_STROBE_MASK_LINE 5
`define PSD_SY_RST 6
`define PSD_SY_DQ_LO 7
`define PSD_SY_DQ_HI 14
`define PSD_SY_W 15
// Reset values
`define PSD_SY_RST_VAL 15'h007f
`define PSD_BYTE_RST 8'h00

`endif

// ==== psd_buf2.v ====
`timescale 1ns/10ps
// Two-entry elastic buffer; ready and valid are registered flags
module psd_buf2 #(
   parameter W = 8
) (
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire flush_i,
   input wire [W-1:0] in_data_i,
   input wire in_valid_i,
   output reg in_ready_o,
   output wire [W-1:0] out_data_o,
   output reg out_valid_o,
   input wire out_ready_i
);
   reg [W-1:0] mem_q [0:1];
   reg wptr_q;
   reg rptr_q;
   reg [1:0] cnt_q;
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;
   wire [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

   assign out_data_o = mem_q[rptr_q];

   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wptr_q <= 1'b0;
         rptr_q <= 1'b0;
         cnt_q <= 2'd0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else if (flush_i) begin
         wptr_q <= 1'b0;
         rptr_q <= 1'b0;
         cnt_q <= 2'd0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wptr_q <= ~wptr_q;
         end
         if (pop) begin
            rptr_q <= ~rptr_q;
         end
         cnt_q <= cnt_d;
         in_ready_o <= (cnt_d != 2'd2);
         out_valid_o <= (cnt_d != 2'd0);
      end
   end

   always @(posedge clk_sys_i) begin
      if (push) begin
         mem_q[wptr_q] <= in_data_i;
      end
   end
endmodule // psd_buf2

// ==== psd_bus_iface.v ====
// Functional notes
// - Select falling starts, rising ends a transaction
// - Transfer on clock crossing; single-ended variant ignores complement
// - Command and data bytes use eight data lines
// - Option fitted: strobe timed from shifted clock
// - Shifted clock causes each read strobe transition; the clear to 0 on the last latency edge follows the link clock
// - Shifted clock ignored during writes
// - Differential shifted clock, or true input only
// - Writes: strobe line is host-driven byte mask
// - Strobe output at start flags extra latency
// - Reset pin low: idle, strobe and data released
`timescale 1ns/10ps
`include "psd_map.vh"
module psd_bus_iface #(
   parameter DIFF_CLK = 1,
   parameter CENTRED = 1,
   parameter [4:0] LAT_CLKS = `PSD_LAT_CLKS
) (
   input wire clk_sys_i,
   input wire arst_n_i,
   // Bus pins
   input wire select_n_i,
   input wire clock_true_i,
   input wire clock_complement_i,
   input wire shifted_clock_i,
   input wire shifted_clock_complement_i,
   input wire hw_reset_n_i,
   input wire [7:0] dq_i,
   output reg [7:0] dq_o,
   output reg dq_oe_o,
   input wire strobe_mask_line_i,
   output reg strobe_mask_line_o,
   output reg strobe_mask_line_oe_o,
   // Core side
   input wire extra_latency_i,
   output reg [`PSD_CA_W-1:0] cmd_o,
   output reg cmd_valid_o,
   output reg cmd_read_o,
   output reg [7:0] wr_data_o,
   output reg wr_mask_o,
   output reg wr_valid_o,
   input wire [7:0] rd_data_i,
   input wire rd_valid_i,
   output wire rd_ready_o,
   output reg underrun_o,
   output reg busy_o
);
   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_CA = 5'b00010;
   localparam [4:0] ST_LAT = 5'b00100;
   localparam [4:0] ST_RD = 5'b01000;
   localparam [4:0] ST_WR = 5'b10000;

   // Crossing value of a clock pair; equal levels hold the last value
   function pair_level;
      input diff;
      input t;
      input c;
      input prev;
      begin
         if (!diff) begin
            pair_level = t;
         end else if (t != c) begin
            pair_level = t;
         end else begin
            pair_level = prev;
         end
      end
   endfunction

   // Pins cross into clk_sys through two flops each
   reg [`PSD_SY_W-1:0] sy1_q;
   reg [`PSD_SY_W-1:0] sy2_q;
   wire [`PSD_SY_W-1:0] pins = {dq_i, hw_reset_n_i, strobe_mask_line_i,
                                shifted_clock_complement_i, shifted_clock_i,
                                clock_complement_i, clock_true_i, select_n_i};

   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sy1_q <= `PSD_SY_RST_VAL;
         sy2_q <= `PSD_SY_RST_VAL;
      end else begin
         sy1_q <= pins;
         sy2_q <= sy1_q;
      end
   end

   wire cs_n_s = sy2_q[`PSD_SY_CS];
   wire hrst_n_s = sy2_q[`PSD_SY_RST];
   wire strobe_mask_line_s = sy2_q[`PSD_SY_STROBE_MASK_LINE];
   wire [7:0] dq_s = sy2_q[`PSD_SY_DQ_HI:`PSD_SY_DQ_LO];

   reg cs_n_prev_q;
   reg ck_lvl_q;
   reg psc_lvl_q;
   wire ck_lvl_d = pair_level(DIFF_CLK != 0, sy2_q[`PSD_SY_CK],
                              sy2_q[`PSD_SY_CKN], ck_lvl_q);
   wire psc_lvl_d = pair_level(DIFF_CLK != 0, sy2_q[`PSD_SY_PSC],
                               sy2_q[`PSD_SY_PSCN], psc_lvl_q);
   wire ck_edge = ck_lvl_d != ck_lvl_q;
   wire psc_edge = psc_lvl_d != psc_lvl_q;
   wire cs_fall = cs_n_prev_q & ~cs_n_s;
   wire cs_rise = ~cs_n_prev_q & cs_n_s;

   reg [4:0] state_q;
   reg [2:0] ca_cnt_q;
   reg [5:0] lat_cnt_q;
   reg [`PSD_CA_W-9:0] ca_sr_q;
   reg is_read_q;

   wire [7:0] buf_data;
   wire buf_valid;
   wire rd_pop = (state_q == ST_RD) & ck_edge & cs_n_s == 1'b0 & hrst_n_s;

   psd_buf2 #(
      .W(8)
   ) u_rd_buf (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .flush_i(~hrst_n_s),
      .in_data_i(rd_data_i),
      .in_valid_i(rd_valid_i),
      .in_ready_o(rd_ready_o),
      .out_data_o(buf_data),
      .out_valid_o(buf_valid),
      .out_ready_i(rd_pop)
   );

   wire [5:0] lat_base = {LAT_CLKS, 1'b0};
   wire [5:0] lat_edges = strobe_mask_line_o ? {lat_base[4:0], 1'b0} : lat_base;

   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_IDLE;
         cs_n_prev_q <= 1'b1;
         ck_lvl_q <= 1'b0;
         psc_lvl_q <= 1'b0;
         ca_cnt_q <= 3'd0;
         lat_cnt_q <= 6'd0;
         ca_sr_q <= {(`PSD_CA_W-8){1'b0}};
         is_read_q <= 1'b0;
         dq_o <= `PSD_BYTE_RST;
         dq_oe_o <= 1'b0;
         strobe_mask_line_o <= 1'b0;
         strobe_mask_line_oe_o <= 1'b0;
         cmd_o <= {`PSD_CA_W{1'b0}};
         cmd_valid_o <= 1'b0;
         cmd_read_o <= 1'b0;
         wr_data_o <= `PSD_BYTE_RST;
         wr_mask_o <= 1'b0;
         wr_valid_o <= 1'b0;
         underrun_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         cs_n_prev_q <= cs_n_s;
         ck_lvl_q <= ck_lvl_d;
         psc_lvl_q <= psc_lvl_d;
         cmd_valid_o <= 1'b0;
         wr_valid_o <= 1'b0;
         underrun_o <= 1'b0;
         if (!hrst_n_s) begin
            // Pin reset wins over any bus activity
            state_q <= ST_IDLE;
            dq_oe_o <= 1'b0;
            strobe_mask_line_oe_o <= 1'b0;
            busy_o <= 1'b0;
         end else if (cs_rise || cs_n_s) begin
            state_q <= ST_IDLE;
            dq_oe_o <= 1'b0;
            strobe_mask_line_oe_o <= 1'b0;
            busy_o <= 1'b0;
         end else if (cs_fall) begin
            state_q <= ST_CA;
            ca_cnt_q <= 3'd0;
            busy_o <= 1'b1;
            strobe_mask_line_oe_o <= 1'b1;
            strobe_mask_line_o <= extra_latency_i;
         end else begin
            case (state_q)
               ST_CA: begin
                  if (ck_edge) begin
                     ca_sr_q <= {ca_sr_q[`PSD_CA_W-17:0], dq_s};
                     ca_cnt_q <= ca_cnt_q + 3'd1;
                     if (ca_cnt_q == `PSD_CA_LAST) begin
                        cmd_o <= {ca_sr_q, dq_s};
                        cmd_valid_o <= 1'b1;
                        // First byte sits in the top eight bits of the shifter
                        cmd_read_o <= ca_sr_q[`PSD_CA_W-16+`PSD_CA_RD_BIT];
                        is_read_q <= ca_sr_q[`PSD_CA_W-16+`PSD_CA_RD_BIT];
                        lat_cnt_q <= lat_edges;
                        state_q <= ST_LAT;
                     end
                  end
               end
               ST_LAT: begin
                  if (!is_read_q) begin
                     // Host owns the line as a mask once the address is in
                     strobe_mask_line_oe_o <= 1'b0;
                  end
                  if (ck_edge) begin
                     lat_cnt_q <= lat_cnt_q - 6'd1;
                     if (lat_cnt_q == 6'd1) begin
                        if (is_read_q) begin
                           state_q <= ST_RD;
                           dq_oe_o <= 1'b1;
                           strobe_mask_line_o <= 1'b0;
                        end else begin
                           state_q <= ST_WR;
                        end
                     end
                  end
               end
               ST_RD: begin
                  if (ck_edge) begin
                     if (buf_valid) begin
                        dq_o <= buf_data;
                     end else begin
                        // Core too slow: last byte repeats, flagged
                        underrun_o <= 1'b1;
                     end
                     if (CENTRED == 0) begin
                        strobe_mask_line_o <= ck_lvl_d;
                     end
                  end
                  if (CENTRED != 0 && psc_edge) begin
                     strobe_mask_line_o <= psc_lvl_d;
                  end
               end
               ST_WR: begin
                  // Shifted clock is not looked at here
                  if (ck_edge) begin
                     wr_data_o <= dq_s;
                     wr_mask_o <= strobe_mask_line_s;
                     wr_valid_o <= 1'b1;
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // psd_bus_iface

// ==== psd_bus_iface_properties.sv ====
`timescale 1ns/10ps
module psd_bus_iface_properties (
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire select_n_i,
   input wire shifted_clock_i,
   input wire hw_reset_n_i,
   input wire extra_latency_i,
   input wire strobe_mask_line_o,
   input wire strobe_mask_line_oe_o,
   input wire dq_oe_o,
   input wire [47:0] cmd_o,
   input wire cmd_valid_o,
   input wire cmd_read_o,
   input wire wr_valid_o,
   input wire busy_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   sel_start_busy_a: assert property ($fell(select_n_i) |-> ##[1:3] busy_o)
      else $error("busy missing after select fall");
   sel_end_idle_a: assert property ($rose(select_n_i) |-> ##[1:4] !(busy_o | dq_oe_o))
      else $error("bus not released after select rise");
   latency_flag_a: assert property ($fell(select_n_i) |->
      ##[2:4] (strobe_mask_line_oe_o && strobe_mask_line_o == extra_latency_i))
      else $error("latency flag wrong");
   pin_reset_a: assert property (!hw_reset_n_i [*4] |->
      !(dq_oe_o | strobe_mask_line_oe_o | busy_o)) else $error("pins driven in reset");
   write_mask_a: assert property (wr_valid_o |-> !(strobe_mask_line_oe_o | dq_oe_o))
      else $error("device drives during write");
   read_bit_a: assert property (cmd_valid_o |-> (cmd_read_o == cmd_o[47]) ##1 !cmd_valid_o)
      else $error("command pulse or direction wrong");
   read_only_drive_a: assert property (dq_oe_o |-> cmd_read_o)
      else $error("data driven outside read");
   strobe_follow_a: assert property (dq_oe_o && $past(dq_oe_o) &&
      $changed(strobe_mask_line_o) |-> strobe_mask_line_o == $past(shifted_clock_i, 2))
      else $error("read strobe not from shifted clock");
   cover property (cmd_valid_o && cmd_read_o);
   cover property (wr_valid_o);
   cover property (strobe_mask_line_oe_o && strobe_mask_line_o);
endmodule // psd_bus_iface_properties
bind psd_bus_iface psd_bus_iface_properties psd_bus_iface_properties_inst (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .select_n_i(select_n_i),
   .shifted_clock_i(shifted_clock_i), .hw_reset_n_i(hw_reset_n_i),
   .extra_latency_i(extra_latency_i), .strobe_mask_line_o(strobe_mask_line_o),
   .strobe_mask_line_oe_o(strobe_mask_line_oe_o), .dq_oe_o(dq_oe_o), .cmd_o(cmd_o),
   .cmd_valid_o(cmd_valid_o), .cmd_read_o(cmd_read_o), .wr_valid_o(wr_valid_o), .busy_o(busy_o));

// ==== psd_host_model.sv ====
`timescale 1ns/10ps
module psd_host_model #(
   parameter LAT = 2
) (
   input wire clk_sys_i,
   input wire [7:0] dev_dq_i,
   input wire dev_dq_oe_i,
   input wire dev_st_i,
   input wire dev_st_oe_i,
   output reg select_n_o,
   output reg ck_o,
   output reg psc_o,
   output wire [7:0] dq_o,
   output wire st_o
);
   reg [7:0] h_dq = 8'h00;
   reg h_oe = 1'b0;
   reg h_st = 1'b0;
   reg h_st_oe = 1'b0;
   reg flag = 1'b0;
   reg [7:0] rq [0:15];
   integer i;
   // Released lines show the inverse of the last value, never a kind guess
   assign dq_o = dev_dq_oe_i ? dev_dq_i : (h_oe ? h_dq : ~h_dq);
   assign st_o = dev_st_oe_i ? dev_st_i : (h_st_oe ? h_st : ~h_st);
   initial begin
      select_n_o = 1'b1;
      ck_o = 1'b0;
      psc_o = 1'b0;
   end
   // Shifted clock trails by a quarter period: 90 degrees
   task edge_step(input shift);
      begin
         ck_o = ~ck_o;
         repeat (2) @(negedge clk_sys_i);
         if (shift) psc_o = ck_o;
         repeat (2) @(negedge clk_sys_i);
      end
   endtask
   task xfer(input [47:0] ca, input integer n, input [7:0] wb, input mask);
      begin
         @(negedge clk_sys_i);
         select_n_o = 1'b0;
         repeat (4) @(negedge clk_sys_i);
         flag = st_o;
         h_oe = 1'b1;
         for (i = 0; i < 6; i = i + 1) begin
            h_dq = ca[47 - 8 * i -: 8];
            edge_step(1'b0);
         end
         h_oe = 1'b0;
         h_st_oe = !ca[47];
         for (i = 0; i < 2 * LAT * (flag + 1); i = i + 1) edge_step(1'b0);
         for (i = 0; i < n; i = i + 1) begin
            h_oe = !ca[47];
            h_dq = wb + i;
            h_st = mask ^ i[0];
            edge_step(ca[47]);
            rq[i] = dq_o;
         end
         h_oe = 1'b0;
         h_st_oe = 1'b0;
         // Frames here stay under 4.0 us only, so this host models the industrial grade
         select_n_o = 1'b1;
         repeat (4) @(negedge clk_sys_i);
      end
   endtask
endmodule // psd_host_model

// ==== tb_psd_bus_iface.sv ====
`timescale 1ns/10ps
module tb_psd_bus_iface;
   reg clk_sys_i = 1'b0;
   reg arst_n_i = 1'b0;
   reg hw_rst_n = 1'b1;
   reg xlat = 1'b0;
   reg [7:0] rd_data = 8'ha0;
   reg rd_valid = 1'b0;
   reg ur = 1'b0;
   reg [7:0] wq [0:15];
   reg mq [0:15];
   integer fails = 0, n_compared = 0, cyc = 0, nw = 0, k;
   wire sel_n, ck, shifted_clock, st_ln, st_dev, st_oe, dq_oe, cmd_rd, wr_mask, wr_valid, rd_ready, underrun;
   wire busy;
   wire [7:0] dq_ln, dq_dev, wr_data;
   wire [47:0] cmd;
   psd_host_model #(.LAT(2)) psd_host_model_inst (.clk_sys_i(clk_sys_i), .dev_dq_i(dq_dev),
      .dev_dq_oe_i(dq_oe), .dev_st_i(st_dev), .dev_st_oe_i(st_oe), .select_n_o(sel_n),
      .ck_o(ck), .psc_o(shifted_clock), .dq_o(dq_ln), .st_o(st_ln));
   psd_bus_iface #(.LAT_CLKS(5'd2)) psd_bus_iface_inst (.clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i), .select_n_i(sel_n), .clock_true_i(ck), .clock_complement_i(~ck),
      .shifted_clock_i(shifted_clock), .shifted_clock_complement_i(~shifted_clock), .hw_reset_n_i(hw_rst_n),
      .dq_i(dq_ln), .dq_o(dq_dev), .dq_oe_o(dq_oe), .strobe_mask_line_i(st_ln),
      .strobe_mask_line_o(st_dev), .strobe_mask_line_oe_o(st_oe), .extra_latency_i(xlat),
      .cmd_o(cmd), .cmd_valid_o(), .cmd_read_o(cmd_rd), .wr_data_o(wr_data),
      .wr_mask_o(wr_mask), .wr_valid_o(wr_valid), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
      .rd_ready_o(rd_ready), .underrun_o(underrun), .busy_o(busy));
   initial forever #12.5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      if (rd_valid && rd_ready) rd_data <= rd_data + 8'h01;
      if (underrun) ur <= 1'b1;
      if (wr_valid) begin
         wq[nw] <= wr_data;
         mq[nw] <= wr_mask;
         nw <= nw + 1;
      end
      cyc = cyc + 1;
      if (cyc == 4000) begin
         fails = fails + 1;
         close_out;
      end
   end
   task chk(input [63:0] got, input [63:0] exp, input [8*8-1:0] what);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("unexpected %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task close_out;
      begin
         $display("compared %0d mismatches %0d", n_compared, fails);
         if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task t_write;
      begin
         nw = 0;
         psd_host_model_inst.xfer(48'h1234_5678_9abc, 8, 8'h30, 1'b1);
         chk(psd_host_model_inst.flag, 1'b0, "flag");
         chk(cmd, 48'h1234_5678_9abc, "cmd");
         chk(nw, 8, "wcount");
         for (k = 0; k < 8; k = k + 1) begin
            chk(wq[k], 8'h30 + k, "wdata");
            chk(mq[k], !k[0], "wmask");
         end
         $display("write test done");
      end
   endtask
   task t_read;
      begin
         rd_valid = 1'b1;
         repeat (6) @(negedge clk_sys_i);
         chk(rd_ready, 1'b0, "full");
         xlat = 1'b1;
         psd_host_model_inst.xfer(48'h8000_0000_0010, 8, 8'h00, 1'b0);
         chk(psd_host_model_inst.flag, 1'b1, "flag");
         chk(cmd_rd, 1'b1, "cmd_rd");
         chk(ur, 1'b0, "underrun");
         for (k = 0; k < 8; k = k + 1) chk(psd_host_model_inst.rq[k], 8'ha0 + k, "rdata");
         rd_valid = 1'b0;
         xlat = 1'b0;
         $display("read test done");
      end
   endtask
   task t_pin_reset;
      fork
         psd_host_model_inst.xfer(48'h0000_0000_0000, 4, 8'h55, 1'b0);
         begin
            repeat (40) @(negedge clk_sys_i);
            hw_rst_n = 1'b0;
            repeat (4) @(negedge clk_sys_i);
            chk(dq_oe | st_oe | busy, 1'b0, "released");
            hw_rst_n = 1'b1;
            $display("pin reset test done");
         end
      join
   endtask
   initial begin
      repeat (4) @(negedge clk_sys_i);
      arst_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      chk({busy, dq_oe, st_oe, rd_ready}, 4'h1, "idle");
      t_write;
      t_read;
      t_pin_reset;
      close_out;
   end
endmodule // tb_psd_bus_iface
